// ==== verilog/traffic_ctrl_pkg.sv ====
package traffic_ctrl_pkg;

    localparam int          ADDR_W              = 8;
    localparam int          REG_W               = 32;
    localparam int          WIDE_W              = 64;

    // Monitor register map
    localparam logic [7:0]  RX_EXPECTED_OFS     = 8'h00;
    localparam logic [7:0]  RX_GOOD_OFS         = 8'h04;
    localparam logic [7:0]  RX_BAD_OFS          = 8'h08;
    localparam logic [7:0]  RX_OCTETS_LOW_OFS   = 8'h0C;
    localparam logic [7:0]  RX_OCTETS_HIGH_OFS  = 8'h10;
    localparam logic [7:0]  RX_CYCLES_LOW_OFS   = 8'h14;
    localparam logic [7:0]  RX_CYCLES_HIGH_OFS  = 8'h18;
    localparam logic [7:0]  MON_CTRL_OFS        = 8'h1C;

    // Generator register map
    localparam logic [7:0]  GEN_TOTAL_OFS       = 8'h40;
    localparam logic [7:0]  GEN_CTRL_OFS        = 8'h48;
    localparam logic [7:0]  GEN_SENT_OFS        = 8'h64;

    // Generator control word fields
    localparam int          GEN_START_BIT       = 0;
    localparam int          GEN_HALT_BIT        = 1;
    localparam int          GEN_DONE_BIT        = 2;

    // Monitor control word fields
    localparam int          MON_START_BIT       = 0;
    localparam int          MON_HALT_BIT        = 1;
    localparam int          MON_DONE_BIT        = 2;
    localparam int          MON_CRC_BAD_BIT     = 3;
    localparam int          MON_MAC_ERR_BIT     = 4;

    localparam logic [31:0] REG_RESET           = 32'h0000_0000;
    localparam logic [63:0] WIDE_RESET          = 64'h0000_0000_0000_0000;

    typedef enum logic {GEN_IDLE, GEN_SEND} gen_state_e;
    typedef enum logic {MON_IDLE, MON_RUN}  mon_state_e;

endpackage : traffic_ctrl_pkg

// ==== verilog/traffic_ctrl.sv ====
// Notes on behaviour
// RQ1: Writing start bit begins frame generation; bit clears itself once sending began.
// RQ2: Halt bit stops further frames; the frame in flight completes first.
// RQ3: Writing generator start clears the generator halt bit.
// RQ4: Generator done bit sets after all programmed frames; start write clears it.
// RQ5: Generator control bits 31 to 3 always read zero.
// RQ6: Read-write 32-bit expected frame total at offset zero.
// RQ7: Read-only count of error-free received frames at offset four.
// RQ8: Read-only count of errored received frames at offset eight.
// RQ9: Wide received octet counter, low word 0x0C, high word 0x10.
// RQ10: Active cycle counter from first byte to last byte, 0x14 and 0x18.
// RQ11: Monitor start bit begins reception and clears itself once started.
// RQ12: Monitor halt freezes all statistics at once; start write clears it.
// RQ13: Monitor done bit sets when expected frames arrived; start clears it.
// RQ14: CRC-failure bit shows the latest frame's check result, refreshed per frame.
// RQ15: MAC receive error bit is sampled on each frame's final octet.
// RQ16: One active-low reset initialises everything to table reset values.
// RQ17: Registers and statistics run on the design clock, not transceiver clock.
// RQ18: Monitor start zeroes all reception statistics before new frames count.
// RQ19: Generator sent-frame count resets when generator start is written.
// RQ20: Monitor control bits 31 to 5 read zero and ignore writes.
//
// Chosen here: the APB interface to the registers.
module traffic_ctrl
    import traffic_ctrl_pkg::*;
#(
    parameter int DATA_W      = 64,
    parameter int EMPTY_W     = 3,
    parameter int FRAME_BEATS = 8
) (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [traffic_ctrl_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    output logic                                 tx_valid,
    input  wire logic                            tx_ready,
    output logic                                 tx_sop,
    output logic                                 tx_eop,
    output logic      [DATA_W-1:0]               tx_data,
    output logic      [EMPTY_W-1:0]              tx_empty,
    input  wire logic                            rx_valid,
    input  wire logic                            rx_sop,
    input  wire logic                            rx_eop,
    input  wire logic [EMPTY_W-1:0]              rx_empty,
    input  wire logic                            rx_err,
    input  wire logic                            rx_crc_bad
);
    import traffic_ctrl_pkg::*;

    localparam int          BEAT_W      = $clog2(FRAME_BEATS + 1);
    localparam logic [6:0]  BEAT_OCTETS = 7'(DATA_W / 8);

    // RQ17: everything below runs on pclk only
    // APB slave
    logic                 pready_r;
    logic                 pslverr_r;
    logic [31:0]          prdata_r;

    wire                  access     = psel & penable & ~pready_r;
    wire                  wr_commit  = psel & penable & pready_r & pwrite;
    wire                  hit_rx_exp = (paddr == RX_EXPECTED_OFS);
    wire                  hit_mon    = (paddr == MON_CTRL_OFS);
    wire                  hit_gtot   = (paddr == GEN_TOTAL_OFS);
    wire                  hit_gctl   = (paddr == GEN_CTRL_OFS);
    wire                  gen_start_wr = wr_commit & hit_gctl & pwdata[GEN_START_BIT];
    wire                  gen_halt_wr  = wr_commit & hit_gctl & pwdata[GEN_HALT_BIT];
    wire                  mon_start_wr = wr_commit & hit_mon & pwdata[MON_START_BIT];
    wire                  mon_halt_wr  = wr_commit & hit_mon & pwdata[MON_HALT_BIT];

    // Generator state
    gen_state_e           gen_state_r;
    logic [31:0]          gen_total_r;
    logic [31:0]          gen_sent_r;
    logic                 gen_start_r;
    logic                 gen_halt_r;
    logic                 gen_done_r;
    logic [BEAT_W-1:0]    beat_r;
    logic                 tx_valid_r;
    logic                 tx_sop_r;
    logic                 tx_eop_r;
    logic [DATA_W-1:0]    tx_data_r;

    // Monitor state
    mon_state_e           mon_state_r;
    logic [31:0]          rx_expected_r;
    logic [31:0]          rx_good_r;
    logic [31:0]          rx_bad_r;
    logic [63:0]          rx_octets_r;
    logic [63:0]          rx_cycles_r;
    logic                 in_span_r;
    logic                 mon_start_r;
    logic                 mon_halt_r;
    logic                 mon_done_r;
    logic                 crc_bad_r;
    logic                 mac_err_r;

    wire [31:0] gen_ctrl_word = {29'h0000_0000, gen_done_r, gen_halt_r, gen_start_r}; // RQ5
    wire [31:0] mon_ctrl_word = {27'h000_0000, mac_err_r, crc_bad_r, mon_done_r,
                                 mon_halt_r, mon_start_r}; // RQ20

    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_ok  = 1'b1;
        case (paddr)
            RX_EXPECTED_OFS:    rd_mux = rx_expected_r;       // RQ6
            RX_GOOD_OFS:        rd_mux = rx_good_r;           // RQ7
            RX_BAD_OFS:         rd_mux = rx_bad_r;            // RQ8
            RX_OCTETS_LOW_OFS:  rd_mux = rx_octets_r[31:0];   // RQ9
            RX_OCTETS_HIGH_OFS: rd_mux = rx_octets_r[63:32];  // RQ9
            RX_CYCLES_LOW_OFS:  rd_mux = rx_cycles_r[31:0];   // RQ10
            RX_CYCLES_HIGH_OFS: rd_mux = rx_cycles_r[63:32];  // RQ10
            MON_CTRL_OFS:       rd_mux = mon_ctrl_word;
            GEN_TOTAL_OFS:      rd_mux = gen_total_r;
            GEN_CTRL_OFS:       rd_mux = gen_ctrl_word;
            GEN_SENT_OFS:       rd_mux = gen_sent_r;
            default: begin
                rd_mux = REG_RESET;
                rd_ok  = 1'b0;
            end
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= REG_RESET;
        end else begin
            pready_r  <= access;
            pslverr_r <= access & ~rd_ok;
            if (access && !pwrite) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // Configuration words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_expected_r <= REG_RESET; // RQ16
            gen_total_r   <= REG_RESET;
        end else begin
            if (wr_commit && hit_rx_exp) begin
                rx_expected_r <= pwdata; // RQ6
            end
            if (wr_commit && hit_gtot) begin
                gen_total_r <= pwdata;
            end
        end
    end

    // Generator
    wire tx_accept  = tx_valid_r & tx_ready;
    wire frame_end  = tx_accept & tx_eop_r;
    wire last_frame = (gen_sent_r + 32'h0000_0001 >= gen_total_r);
    wire beat_last  = (beat_r == BEAT_W'(FRAME_BEATS - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_state_r <= GEN_IDLE;
            gen_sent_r  <= REG_RESET;
            gen_start_r <= 1'b0;
            gen_halt_r  <= 1'b0;
            gen_done_r  <= 1'b0;
        end else if (gen_start_wr) begin
            gen_start_r <= 1'b1;                            // RQ1
            gen_halt_r  <= 1'b0;                            // RQ3
            gen_done_r  <= 1'b0;                            // RQ4
            gen_sent_r  <= REG_RESET;                       // RQ19
            gen_state_r <= GEN_IDLE;
        end else begin
            if (gen_halt_wr) begin
                gen_halt_r <= 1'b1;
            end
            case (gen_state_r)
                GEN_IDLE: begin
                    if (gen_start_r) begin
                        gen_start_r <= 1'b0;                // RQ1
                        if (gen_total_r == REG_RESET) begin
                            gen_done_r <= 1'b1;             // RQ4
                        end else begin
                            gen_state_r <= GEN_SEND;
                        end
                    end
                end
                GEN_SEND: begin
                    if (frame_end) begin
                        gen_sent_r <= gen_sent_r + 32'h0000_0001;
                        if (last_frame) begin
                            gen_done_r  <= 1'b1;            // RQ4
                            gen_state_r <= GEN_IDLE;
                        end else if (gen_halt_r || gen_halt_wr) begin
                            gen_state_r <= GEN_IDLE;        // RQ2
                        end
                    end
                end
                default: gen_state_r <= GEN_IDLE;
            endcase
        end
    end

    // Transmit stream: a beat holds until accepted, so a halted frame still completes
    wire gen_launch = (gen_state_r == GEN_IDLE) & gen_start_r & ~gen_start_wr
                      & (gen_total_r != REG_RESET);
    wire gen_stop   = frame_end & (last_frame | gen_halt_r | gen_halt_wr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid_r <= 1'b0;
            tx_sop_r   <= 1'b0;
            tx_eop_r   <= 1'b0;
            beat_r     <= '0;
            tx_data_r  <= '0;
        end else if (gen_start_wr || gen_stop) begin
            tx_valid_r <= 1'b0;                             // RQ2
            tx_sop_r   <= 1'b0;
            tx_eop_r   <= 1'b0;
            beat_r     <= '0;
        end else if (gen_launch || (tx_accept && tx_eop_r)) begin
            tx_valid_r <= 1'b1;
            tx_sop_r   <= 1'b1;
            tx_eop_r   <= (FRAME_BEATS == 1);
            beat_r     <= '0;
            if (tx_accept) begin
                tx_data_r <= tx_data_r + DATA_W'(1);
            end
        end else if (tx_accept) begin
            tx_sop_r   <= 1'b0;
            tx_eop_r   <= (beat_r == BEAT_W'(FRAME_BEATS - 2));
            beat_r     <= beat_last ? beat_r : beat_r + BEAT_W'(1);
            tx_data_r  <= tx_data_r + DATA_W'(1);
        end
    end

    // Monitor
    wire        mon_live   = (mon_state_r == MON_RUN) & ~mon_halt_r & ~mon_halt_wr; // RQ12
    wire        rx_beat    = mon_live & rx_valid;
    wire        rx_end     = rx_beat & rx_eop;
    wire        rx_bad_now = rx_err | rx_crc_bad;
    wire [31:0] rx_seen    = rx_good_r + rx_bad_r + 32'h0000_0001;
    wire [63:0] beat_bytes = 64'(BEAT_OCTETS - 7'(rx_empty & {EMPTY_W{rx_eop}}));
    wire        span_on    = in_span_r | (rx_beat & rx_sop);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_state_r <= MON_IDLE;
            mon_start_r <= 1'b0;
            mon_halt_r  <= 1'b0;
            mon_done_r  <= 1'b0;
            rx_good_r   <= REG_RESET;
            rx_bad_r    <= REG_RESET;
            rx_octets_r <= WIDE_RESET;
            rx_cycles_r <= WIDE_RESET;
            in_span_r   <= 1'b0;
            crc_bad_r   <= 1'b0;
            mac_err_r   <= 1'b0;
        end else if (mon_start_wr) begin
            mon_start_r <= 1'b1;                            // RQ11
            mon_halt_r  <= 1'b0;                            // RQ12
            mon_done_r  <= 1'b0;                            // RQ13
            rx_good_r   <= REG_RESET;                       // RQ18
            rx_bad_r    <= REG_RESET;                       // RQ18
            rx_octets_r <= WIDE_RESET;                      // RQ18
            rx_cycles_r <= WIDE_RESET;                      // RQ18
            in_span_r   <= 1'b0;
            mon_state_r <= MON_IDLE;
        end else begin
            if (mon_halt_wr) begin
                mon_halt_r <= 1'b1;                         // RQ12
            end
            if (mon_start_r) begin
                mon_start_r <= 1'b0;                        // RQ11
                mon_state_r <= MON_RUN;
            end
            if (rx_beat) begin
                rx_octets_r <= rx_octets_r + beat_bytes;    // RQ9
            end
            if (mon_live && span_on) begin
                rx_cycles_r <= rx_cycles_r + WIDE_W'(1);    // RQ10
            end
            if (mon_live && rx_beat && rx_sop) begin
                in_span_r <= 1'b1;
            end
            if (rx_end) begin
                crc_bad_r <= rx_crc_bad;                    // RQ14
                mac_err_r <= rx_err;                        // RQ15
                if (rx_bad_now) begin
                    rx_bad_r <= rx_bad_r + 32'h0000_0001;   // RQ8
                end else begin
                    rx_good_r <= rx_good_r + 32'h0000_0001; // RQ7
                end
                if (rx_seen == rx_expected_r) begin
                    mon_done_r  <= 1'b1;                    // RQ13
                    in_span_r   <= 1'b0;                    // RQ10
                    mon_state_r <= MON_IDLE;
                end
            end
        end
    end

    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign tx_valid = tx_valid_r;
    assign tx_sop   = tx_sop_r;
    assign tx_eop   = tx_eop_r;
    assign tx_data  = tx_data_r;
    assign tx_empty = '0;

endmodule : traffic_ctrl

// ==== dv/traffic_ctrl_chk.sv ====
module traffic_ctrl_chk #(
    parameter int DATA_W      = 64,
    parameter int EMPTY_W     = 3,
    parameter int FRAME_BEATS = 8
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               tx_valid,
    input wire logic               tx_ready,
    input wire logic               tx_sop,
    input wire logic               tx_eop,
    input wire logic [DATA_W-1:0]  tx_data,
    input wire logic [EMPTY_W-1:0] tx_empty
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] beat_r;
    wire        take = tx_valid && tx_ready;
    // Position of the current outgoing beat within its frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            beat_r <= 8'h00;
        end else if (take) begin
            beat_r <= tx_eop ? 8'h00 : beat_r + 8'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ack_wait; psel && penable && !pready |=> pready; endproperty
    a_ack_wait: assert property (p_ack_wait) else $error("no answer after one wait");
    property p_ack_pulse; pready |=> !pready; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("answer too long");
    property p_err_ack; pslverr |-> pready; endproperty
    a_err_ack: assert property (p_err_ack) else $error("error without answer");
    property p_err_data; pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
    a_err_data: assert property (p_err_data) else $error("unmapped read not zero");
    property p_tx_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_eop);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("beat changed while stalled");
    property p_tx_full; tx_valid |-> tx_empty == '0; endproperty
    a_tx_full: assert property (p_tx_full) else $error("beat not full");
    property p_tx_step;
        take && !tx_eop |=> tx_valid && !tx_sop && tx_data == $past(tx_data) + 1'b1;
    endproperty
    a_tx_step: assert property (p_tx_step) else $error("frame broken mid-way");
    property p_frame_len; tx_valid && tx_eop |-> beat_r == 8'(FRAME_BEATS - 1); endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
    property p_next_sop; take && tx_eop |=> !tx_valid || tx_sop; endproperty
    a_next_sop: assert property (p_next_sop) else $error("frame without start");
    c_err: cover property (pslverr);
    c_stall: cover property (tx_valid && !tx_ready);
    c_frame_end: cover property (take && tx_eop ##1 !tx_valid);
endmodule : traffic_ctrl_chk

bind traffic_ctrl traffic_ctrl_chk #(
    .DATA_W(DATA_W), .EMPTY_W(EMPTY_W), .FRAME_BEATS(FRAME_BEATS)
) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_data(tx_data),
    .tx_empty(tx_empty)
);

// ==== dv/mac_stream_model.sv ====
module mac_stream_model #(
    parameter int EMPTY_W = 3
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               stall,
    input  wire logic               crc_in,
    input  wire logic               err_in,
    input  wire logic [EMPTY_W-1:0] empty_in,
    input  wire logic               tx_valid,
    input  wire logic               tx_sop,
    input  wire logic               tx_eop,
    output logic                    tx_ready,
    output logic                    rx_valid,
    output logic                    rx_sop,
    output logic                    rx_eop,
    output logic [EMPTY_W-1:0]      rx_empty,
    output logic                    rx_err,
    output logic                    rx_crc_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_r;
    wire        take = tx_valid && tx_ready;
    wire        last = take && tx_eop;
    // Loops each taken beat back a cycle later; idle lines toggle so that
    // the monitor must qualify them with rx_valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r      <= 2'h0;
            tx_ready   <= 1'b0;
            rx_valid   <= 1'b0;
            rx_sop     <= 1'b0;
            rx_eop     <= 1'b0;
            rx_empty   <= '0;
            rx_err     <= 1'b0;
            rx_crc_bad <= 1'b0;
        end else begin
            cnt_r      <= cnt_r + 2'h1;
            tx_ready   <= !(stall && cnt_r == 2'h2);
            rx_valid   <= take;
            rx_sop     <= take ? tx_sop : !rx_sop;
            rx_eop     <= take ? tx_eop : !rx_eop;
            rx_empty   <= last ? empty_in : ~rx_empty;
            rx_err     <= last ? err_in : !rx_err;
            rx_crc_bad <= last ? crc_in : !rx_crc_bad;
        end
    end
endmodule : mac_stream_model

// ==== dv/traffic_ctrl_tb.sv ====
module traffic_ctrl_tb;
    import traffic_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FB = 8;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        stall = 1'b0, crc_in = 1'b0, err_in = 1'b0, last_eop = 1'b0, e;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q, g0;
    logic        pready, pslverr, tx_valid, tx_ready, tx_sop, tx_eop;
    logic        rx_valid, rx_sop, rx_eop, rx_err, rx_crc_bad;
    logic [63:0] tx_data;
    logic [2:0]  tx_empty, rx_empty, empty_in = 3'h3;
    int          error_cnt = 0, checks_done = 0, cyc = 0, eops = 0, e0 = 0, n;
    logic [7:0]  ofs [11] = '{RX_EXPECTED_OFS, RX_GOOD_OFS, RX_BAD_OFS, RX_OCTETS_LOW_OFS,
        RX_OCTETS_HIGH_OFS, RX_CYCLES_LOW_OFS, RX_CYCLES_HIGH_OFS, MON_CTRL_OFS,
        GEN_TOTAL_OFS, GEN_CTRL_OFS, GEN_SENT_OFS};

    traffic_ctrl #(.FRAME_BEATS(FB)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_sop(tx_sop),
        .tx_eop(tx_eop), .tx_data(tx_data), .tx_empty(tx_empty), .rx_valid(rx_valid),
        .rx_sop(rx_sop), .rx_eop(rx_eop), .rx_empty(rx_empty), .rx_err(rx_err),
        .rx_crc_bad(rx_crc_bad));
    mac_stream_model mac (
        .pclk(pclk), .presetn(presetn), .stall(stall), .crc_in(crc_in), .err_in(err_in),
        .empty_in(empty_in), .tx_valid(tx_valid), .tx_sop(tx_sop), .tx_eop(tx_eop),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_sop(rx_sop), .rx_eop(rx_eop),
        .rx_empty(rx_empty), .rx_err(rx_err), .rx_crc_bad(rx_crc_bad));

    always #20 pclk = ~pclk;
    // Counts sent frames and the timeout
    always @(posedge pclk) begin
        cyc++;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            last_eop = tx_eop;
            eops += (tx_eop === 1'b1);
        end
        if (cyc == 30000) begin
            error_cnt++;
            conclude();
        end
    end

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask : wr

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000, q, e);
        check(nm, q, x);
    endtask : rdc

    task wait_done(input logic [7:0] a);
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, a, 32'h0000_0000, q, e);
            if (q[2] === 1'b1) break;
        end
    endtask : wait_done

    task run(input logic [31:0] fr);
        wr(RX_EXPECTED_OFS, fr);
        wr(GEN_TOTAL_OFS, fr);
        wr(MON_CTRL_OFS, 32'h0000_0001);
        e0 = eops;
        wr(GEN_CTRL_OFS, 32'h0000_0001);
        rdc("gen_ctrl_start", GEN_CTRL_OFS, 32'h0000_0000);
    endtask : run

    task conclude();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ofs[i]) rdc("reset_value", ofs[i], 32'h0000_0000);
        wr(RX_EXPECTED_OFS, 32'hA5A5_5A5A);
        rdc("rx_expected", RX_EXPECTED_OFS, 32'hA5A5_5A5A);
        wr(RX_GOOD_OFS, 32'hFFFF_FFFF);
        rdc("rx_good_ro", RX_GOOD_OFS, 32'h0000_0000);
        wr(MON_CTRL_OFS, 32'hFFFF_FFE0);
        rdc("mon_ctrl_reserved", MON_CTRL_OFS, 32'h0000_0000);
        wr(GEN_CTRL_OFS, 32'hFFFF_FFF8);
        rdc("gen_ctrl_reserved", GEN_CTRL_OFS, 32'h0000_0000);
        // A zero frame total finishes at once without sending
        wr(GEN_CTRL_OFS, 32'h0000_0001);
        rdc("gen_zero_total", GEN_CTRL_OFS, 32'h0000_0004);
        rdc("gen_zero_sent", GEN_SENT_OFS, 32'h0000_0000);
        apb(1'b0, 8'h3C, 32'h0000_0000, q, e);
        check("unmapped_err", {31'h0, e}, 32'h0000_0001);
        check("unmapped_data", q, 32'h0000_0000);
        // Runs: all CRC bad, all MAC error, all good without stalls
        for (int r = 0; r < 3; r++) begin
            stall <= (r < 2);
            crc_in <= (r == 0);
            err_in <= (r == 1);
            run(32'h0000_0003);
            wait_done(GEN_CTRL_OFS);
            wait_done(MON_CTRL_OFS);
            rdc("gen_ctrl", GEN_CTRL_OFS, 32'h0000_0004);
            rdc("gen_sent", GEN_SENT_OFS, 32'h0000_0003);
            rdc("mon_ctrl", MON_CTRL_OFS, 32'h4 | 32'(r == 0) << 3 | 32'(r == 1) << 4);
            rdc("rx_good", RX_GOOD_OFS, r == 2 ? 32'h3 : 32'h0);
            rdc("rx_bad", RX_BAD_OFS, r == 2 ? 32'h0 : 32'h3);
            rdc("octets_low", RX_OCTETS_LOW_OFS, 32'(3 * ((FB - 1) * 8 + 5)));
            rdc("octets_high", RX_OCTETS_HIGH_OFS, 32'h0000_0000);
            if (r == 2) rdc("cycles_low", RX_CYCLES_LOW_OFS, 32'(3 * FB));
        end
        rdc("cycles_high", RX_CYCLES_HIGH_OFS, 32'h0000_0000);
        stall <= 1'b1;
        run(32'h0000_000A);
        wr(MON_CTRL_OFS, 32'h0000_0002);
        apb(1'b0, RX_GOOD_OFS, 32'h0000_0000, g0, e);
        wr(GEN_CTRL_OFS, 32'h0000_0002);
        n = 0;
        while (tx_valid !== 1'b0 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        check("halt_idle", {31'h0, tx_valid}, 32'h0000_0000);
        check("last_beat_eop", {31'h0, last_eop}, 32'h0000_0001);
        rdc("gen_sent_halt", GEN_SENT_OFS, 32'(eops - e0));
        rdc("gen_ctrl_halt", GEN_CTRL_OFS, 32'h0000_0002);
        rdc("rx_good_frozen", RX_GOOD_OFS, g0);
        rdc("mon_ctrl_halt", MON_CTRL_OFS, 32'h0000_0002);
        wr(MON_CTRL_OFS, 32'h0000_0001);
        rdc("mon_ctrl_restart", MON_CTRL_OFS, 32'h0000_0000);
        rdc("rx_good_zero", RX_GOOD_OFS, 32'h0000_0000);
        rdc("cycles_zero", RX_CYCLES_LOW_OFS, 32'h0000_0000);
        run(32'h0000_000A);
        wait_done(GEN_CTRL_OFS);
        wait_done(MON_CTRL_OFS);
        rdc("gen_sent_full", GEN_SENT_OFS, 32'h0000_000A);
        rdc("rx_good_full", RX_GOOD_OFS, 32'h0000_000A);
        rdc("mon_ctrl_done", MON_CTRL_OFS, 32'h0000_0004);
        conclude();
    end
endmodule : traffic_ctrl_tb
